// ===== src/rcrq_pkg.sv
/*
 * rcrq_pkg: constants, register map, field positions, reset values,
 * timing counts and carrier types of the reference clock request logic.
 * assumes a 10 MHz core clock and a classic wishbone register bus.
 */
// Overview of operation
// - the internal clock request is high while awake with core power and low while asleep or without core power.
// - polarity strap 0 gives an active-low request pin, strap 1 an active-high one.
// - with the combine strap high the external request input is merged into the request pin.
// - with the combine strap low the pin shows only the internal request and the external input is ignored.
// - combine mode with polarity 1 drives the pin with external OR internal.
// - combine mode with polarity 0 drives the pin with external AND NOT internal.
// - the combining path keeps working while the core sleeps or has no power.
// - with the request feature unused the pin is a plain general-purpose output.
// - while asleep the timing reference is the low-power oscillator, external or internal.
// - the low-power timing source is the external 32.768 kHz clock, else the internal oscillator.
// - the reference frequency defaults to 20 MHz unless set otherwise.
// - with an external low-power clock only the standard frequencies are auto-detected.
package rcrq_pkg;

    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int unsigned RCRQ_CLK_PERIOD_NS = 100;
    localparam int unsigned RCRQ_LPO_HZ        = 32768;
    localparam int unsigned RCRQ_LPO_PERIOD_NS = 30518;
    // two low-power periods without an edge mean the clock is absent
    localparam int unsigned RCRQ_LPO_TMO_NS    = 2 * RCRQ_LPO_PERIOD_NS;
    localparam int unsigned RCRQ_LPO_TMO_CYC   =
        (RCRQ_LPO_TMO_NS + RCRQ_CLK_PERIOD_NS - 1) / RCRQ_CLK_PERIOD_NS;
    localparam int unsigned RCRQ_DET_WIN_LPO   = 4096;
    localparam int unsigned RCRQ_REF_PRESCALE  = 1024;
    localparam int unsigned RCRQ_DET_TOL       = 4;

    // ---------------------------------------------------------------
    // reference frequencies in kHz
    // ---------------------------------------------------------------
    localparam int unsigned RCRQ_NSTD = 17;
    localparam logic [19:0] RCRQ_REF_DEFAULT_KHZ = 20'h04e20;
    localparam int unsigned RCRQ_STD_KHZ [RCRQ_NSTD] = '{
        12000, 13000, 14400, 15360, 16200, 16800, 18000, 19200, 19440,
        19680, 19800, 20000, 24000, 26000, 33600, 37400, 38400};

    // ---------------------------------------------------------------
    // register map, byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] RCRQ_CTRL_OFS   = 8'h00;
    localparam logic [7:0] RCRQ_STATUS_OFS = 8'h04;
    localparam logic [7:0] RCRQ_REFKHZ_OFS = 8'h08;
    localparam logic [7:0] RCRQ_DETCNT_OFS = 8'h0c;

    // control fields
    localparam int unsigned RCRQ_CTRL_REQ_EN   = 0;
    localparam int unsigned RCRQ_CTRL_SLEEP    = 1;
    localparam int unsigned RCRQ_CTRL_GPIO_VAL = 2;
    localparam int unsigned RCRQ_CTRL_GPIO_OE  = 3;
    localparam int unsigned RCRQ_CTRL_REDET    = 4;
    localparam logic [3:0]  RCRQ_CTRL_RESET    = 4'h1;

    // status fields
    localparam int unsigned RCRQ_ST_AWAKE    = 0;
    localparam int unsigned RCRQ_ST_INT_REQ  = 1;
    localparam int unsigned RCRQ_ST_COMBINE  = 2;
    localparam int unsigned RCRQ_ST_POLARITY = 3;
    localparam int unsigned RCRQ_ST_EXT_REQ  = 4;
    localparam int unsigned RCRQ_ST_LPO_EXT  = 5;
    localparam int unsigned RCRQ_ST_LPO_SEL  = 6;
    localparam int unsigned RCRQ_ST_DET_DONE = 7;
    localparam int unsigned RCRQ_ST_DET_HIT  = 8;
    localparam int unsigned RCRQ_ST_DET_IDX  = 12;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } rcrq_wb_req_t;

    typedef enum logic [0:0] {
        RCRQ_AWAKE = 1'b0,
        RCRQ_SLEEP = 1'b1
    } rcrq_pwr_t;

    typedef enum logic [1:0] {
        RCRQ_DET_IDLE = 2'b00,
        RCRQ_DET_RUN  = 2'b01,
        RCRQ_DET_DONE = 2'b10
    } rcrq_det_t;

endpackage

// ===== src/rcrq_sync.sv
/*
 * rcrq_sync: two-flop synchroniser for a group of independent levels.
 * assumes each bit is a slow level or clock from outside the domain.
 */
`timescale 1ns/1ps
module rcrq_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    // next values, frozen while the clock enable is low
    always_comb begin
        meta_next = ce_i ? d_i : meta_reg;
        sync_next = ce_i ? meta_reg : sync_reg;
    end

    // two stages
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign q_o = sync_reg;
endmodule // rcrq_sync

// ===== src/rcrq_top.sv
/*
 * rcrq_top: reference clock request logic with power state, low-power
 * clock supervision, reference auto-detection and a wishbone slave.
 * assumes pins arrive asynchronously and the pad path has its own supply.
 */
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module rcrq_top
    import rcrq_pkg::*;
#(
    parameter int unsigned DET_WIN_LPO = RCRQ_DET_WIN_LPO,
    parameter int unsigned PRESCALE    = RCRQ_REF_PRESCALE,
    parameter int unsigned TOL         = RCRQ_DET_TOL
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire rcrq_wb_req_t wb_req_i,
    output logic [31:0]       wb_dat_o,
    output logic              wb_ack_o,
    input  wire logic         polarity_strap_i,
    input  wire logic         combine_mode_strap_i,
    input  wire logic         core_pwr_i,
    input  wire logic         ext_req_i,
    input  wire logic         wake_i,
    input  wire logic         lpo_ext_i,
    input  wire logic         ref_div_i,
    output logic              req_pin_o,
    output logic              req_pin_oe_o,
    output logic              lpo_sel_o,
    output logic              lpo_src_ext_o,
    output logic [19:0]       ref_khz_o
);
    // ---------------------------------------------------------------
    // parameter checks
    // ---------------------------------------------------------------
    localparam int unsigned CNT_W = 24;
    if (DET_WIN_LPO < 16 || DET_WIN_LPO > 65535)
        $error("detection window out of range");
    if (PRESCALE < 1)
        $error("prescale must be at least one");

    // expected reference ticks over one detection window
    function automatic logic [CNT_W-1:0] expect_cnt(input int unsigned khz);
        longint unsigned v;
        v = (longint'(khz) * 1000 * DET_WIN_LPO) / (longint'(PRESCALE) * RCRQ_LPO_HZ);
        return v[CNT_W-1:0];
    endfunction

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [5:0] pins_s;
    logic       ext_req_s;
    logic       wake_s;
    logic       lpo_s;
    logic       ref_s;
    logic       pol_s;
    logic       comb_s;

    rcrq_sync #(.W(6)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   ({combine_mode_strap_i, polarity_strap_i, ref_div_i, lpo_ext_i, wake_i, ext_req_i}),
        .q_o   (pins_s)
    );
    assign ext_req_s = pins_s[0];
    assign wake_s    = pins_s[1];
    assign lpo_s     = pins_s[2];
    assign ref_s     = pins_s[3];
    assign pol_s     = pins_s[4];
    assign comb_s    = pins_s[5];

    // ---------------------------------------------------------------
    // registers and next values
    // ---------------------------------------------------------------
    rcrq_pwr_t        pwr_reg, pwr_next;
    rcrq_det_t        det_reg, det_next;
    logic [3:0]       ctrl_reg, ctrl_next;
    logic [19:0]      khz_reg, khz_next;
    logic             ack_reg, ack_next;
    logic [31:0]      dat_reg, dat_next;
    logic             lpo_d_reg, lpo_d_next;
    logic             ref_d_reg, ref_d_next;
    logic [9:0]       tmo_reg, tmo_next;
    logic             lpo_ok_reg, lpo_ok_next;
    logic [15:0]      win_reg, win_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] last_reg, last_next;
    logic             hit_reg, hit_next;
    logic [4:0]       idx_reg, idx_next;

    // bus decode
    logic        bus_req;
    logic        bus_wr;
    logic        redet_wr;
    logic        lpo_rise;
    logic        ref_rise;
    logic        int_req;
    logic [31:0] status;
    logic        m_hit;
    logic [4:0]  m_idx;
    logic [CNT_W-1:0] m_exp;
    logic [CNT_W-1:0] m_dif;

    assign bus_req  = wb_req_i.cyc && wb_req_i.stb && !ack_reg;
    assign bus_wr   = bus_req && wb_req_i.we;
    assign redet_wr = bus_wr && wb_req_i.adr == RCRQ_CTRL_OFS && wb_req_i.sel[0]
                      && wb_req_i.dat[RCRQ_CTRL_REDET];
    assign lpo_rise = lpo_s && !lpo_d_reg;
    assign ref_rise = ref_s && !ref_d_reg;

    // ---------------------------------------------------------------
    // power state and internal request
    // ---------------------------------------------------------------
    // internal request follows the awake state; no core power means no request
    assign int_req = core_pwr_i && pwr_reg == RCRQ_AWAKE;

    // sleep entry by software, wake by pin or cleared sleep bit
    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            RCRQ_AWAKE: begin
                if (ctrl_reg[RCRQ_CTRL_SLEEP] && !wake_s)
                    pwr_next = RCRQ_SLEEP;
            end
            RCRQ_SLEEP: begin
                if (wake_s || !ctrl_reg[RCRQ_CTRL_SLEEP])
                    pwr_next = RCRQ_AWAKE;
            end
            default: pwr_next = RCRQ_AWAKE;
        endcase
    end

    // ---------------------------------------------------------------
    // request pin path, no clock involved
    // ---------------------------------------------------------------
    // pad-ring combine uses the raw pins so it works without the core
    always_comb begin
        logic comb_out;
        comb_out = 1'b0;
        if (combine_mode_strap_i) begin
            if (polarity_strap_i)
                comb_out = ext_req_i | int_req;
            else
                comb_out = ext_req_i & ~int_req;
        end else begin
            comb_out = polarity_strap_i ? int_req : ~int_req;
        end
        if (ctrl_reg[RCRQ_CTRL_REQ_EN]) begin
            req_pin_o    = comb_out;
            req_pin_oe_o = 1'b1;
        end else begin
            req_pin_o    = ctrl_reg[RCRQ_CTRL_GPIO_VAL];
            req_pin_oe_o = ctrl_reg[RCRQ_CTRL_GPIO_OE];
        end
    end

    // ---------------------------------------------------------------
    // low-power clock supervision and selection
    // ---------------------------------------------------------------
    // external clock is present while edges keep coming
    always_comb begin
        lpo_d_next  = lpo_s;
        ref_d_next  = ref_s;
        tmo_next    = tmo_reg;
        lpo_ok_next = lpo_ok_reg;
        if (lpo_rise) begin
            tmo_next    = '0;
            lpo_ok_next = 1'b1;
        end else if (tmo_reg == 10'(RCRQ_LPO_TMO_CYC)) begin
            lpo_ok_next = 1'b0;
        end else begin
            tmo_next = tmo_reg + 10'h001;
        end
    end

    assign lpo_src_ext_o = lpo_ok_reg;
    assign lpo_sel_o     = pwr_reg == RCRQ_SLEEP;

    // ---------------------------------------------------------------
    // frequency table match
    // ---------------------------------------------------------------
    // first table entry within tolerance of the window count
    always_comb begin
        m_hit = 1'b0;
        m_idx = '0;
        m_exp = '0;
        m_dif = '0;
        for (int i = 0; i < RCRQ_NSTD; i++) begin
            m_exp = expect_cnt(RCRQ_STD_KHZ[i]);
            m_dif = (cnt_reg > m_exp) ? cnt_reg - m_exp : m_exp - cnt_reg;
            if (!m_hit && m_dif <= CNT_W'(TOL)) begin
                m_hit = 1'b1;
                m_idx = 5'(i);
            end
        end
    end

    // ---------------------------------------------------------------
    // auto-detection sequence
    // ---------------------------------------------------------------
    // count reference ticks over a window of low-power periods
    always_comb begin
        det_next  = det_reg;
        win_next  = win_reg;
        cnt_next  = cnt_reg;
        last_next = last_reg;
        hit_next  = hit_reg;
        idx_next  = idx_reg;
        case (det_reg)
            RCRQ_DET_IDLE: begin
                if (lpo_ok_reg && lpo_rise) begin
                    det_next = RCRQ_DET_RUN;
                    win_next = '0;
                    cnt_next = '0;
                end
            end
            RCRQ_DET_RUN: begin
                if (ref_rise)
                    cnt_next = cnt_reg + CNT_W'(1);
                if (!lpo_ok_reg) begin
                    det_next = RCRQ_DET_DONE;
                    hit_next = 1'b0;
                end else if (lpo_rise) begin
                    if (win_reg == 16'(DET_WIN_LPO - 1)) begin
                        det_next  = RCRQ_DET_DONE;
                        last_next = cnt_reg;
                        hit_next  = m_hit;
                        idx_next  = m_idx;
                    end else begin
                        win_next = win_reg + 16'h0001;
                    end
                end
            end
            RCRQ_DET_DONE: begin
                if (redet_wr) begin
                    det_next = RCRQ_DET_IDLE;
                    hit_next = 1'b0;
                end
            end
            default: det_next = RCRQ_DET_IDLE;
        endcase
    end

    // ---------------------------------------------------------------
    // status word
    // ---------------------------------------------------------------
    always_comb begin
        status = '0;
        status[RCRQ_ST_AWAKE]    = pwr_reg == RCRQ_AWAKE;
        status[RCRQ_ST_INT_REQ]  = int_req;
        status[RCRQ_ST_COMBINE]  = comb_s;
        status[RCRQ_ST_POLARITY] = pol_s;
        status[RCRQ_ST_EXT_REQ]  = ext_req_s;
        status[RCRQ_ST_LPO_EXT]  = lpo_ok_reg;
        status[RCRQ_ST_LPO_SEL]  = lpo_sel_o;
        status[RCRQ_ST_DET_DONE] = det_reg == RCRQ_DET_DONE;
        status[RCRQ_ST_DET_HIT]  = hit_reg;
        status[RCRQ_ST_DET_IDX +: 5] = idx_reg;
    end

    // ---------------------------------------------------------------
    // wishbone slave and register writes
    // ---------------------------------------------------------------
    // one-cycle ack, zero data for unmapped offsets
    always_comb begin
        ctrl_next = ctrl_reg;
        khz_next  = khz_reg;
        ack_next  = bus_req;
        dat_next  = bus_req ? 32'h00000000 : dat_reg;
        // a wake pin clears the sleep request
        if (pwr_reg == RCRQ_SLEEP && wake_s)
            ctrl_next[RCRQ_CTRL_SLEEP] = 1'b0;
        if (bus_wr) begin
            case (wb_req_i.adr)
                RCRQ_CTRL_OFS: begin
                    if (wb_req_i.sel[0])
                        ctrl_next = wb_req_i.dat[3:0];
                end
                RCRQ_REFKHZ_OFS: begin
                    if (wb_req_i.sel[0])
                        khz_next[7:0] = wb_req_i.dat[7:0];
                    if (wb_req_i.sel[1])
                        khz_next[15:8] = wb_req_i.dat[15:8];
                    if (wb_req_i.sel[2])
                        khz_next[19:16] = wb_req_i.dat[19:16];
                end
                default: ;
            endcase
        end else if (bus_req) begin
            case (wb_req_i.adr)
                RCRQ_CTRL_OFS:   dat_next = {28'h0000000, ctrl_reg};
                RCRQ_STATUS_OFS: dat_next = status;
                RCRQ_REFKHZ_OFS: dat_next = {12'h000, khz_reg};
                RCRQ_DETCNT_OFS: dat_next = {8'h00, last_reg};
                default:         dat_next = 32'h00000000;
            endcase
        end
        // a detected standard frequency wins over a software write
        if (det_reg == RCRQ_DET_RUN && det_next == RCRQ_DET_DONE && hit_next)
            khz_next = 20'(RCRQ_STD_KHZ[idx_next]);
    end

    assign wb_ack_o  = ack_reg;
    assign wb_dat_o  = dat_reg;
    assign ref_khz_o = khz_reg;

    // ---------------------------------------------------------------
    // state registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_reg    <= RCRQ_AWAKE;
            det_reg    <= RCRQ_DET_IDLE;
            ctrl_reg   <= RCRQ_CTRL_RESET;
            khz_reg    <= RCRQ_REF_DEFAULT_KHZ;
            ack_reg    <= 1'b0;
            dat_reg    <= '0;
            lpo_d_reg  <= 1'b0;
            ref_d_reg  <= 1'b0;
            tmo_reg    <= '0;
            lpo_ok_reg <= 1'b0;
            win_reg    <= '0;
            cnt_reg    <= '0;
            last_reg   <= '0;
            hit_reg    <= 1'b0;
            idx_reg    <= '0;
        end else if (ce_i) begin
            pwr_reg    <= pwr_next;
            det_reg    <= det_next;
            ctrl_reg   <= ctrl_next;
            khz_reg    <= khz_next;
            ack_reg    <= ack_next;
            dat_reg    <= dat_next;
            lpo_d_reg  <= lpo_d_next;
            ref_d_reg  <= ref_d_next;
            tmo_reg    <= tmo_next;
            lpo_ok_reg <= lpo_ok_next;
            win_reg    <= win_next;
            cnt_reg    <= cnt_next;
            last_reg   <= last_next;
            hit_reg    <= hit_next;
            idx_reg    <= idx_next;
        end
    end
endmodule // rcrq_top

// ===== dv/rcrq_monitor.sv
/*
 * rcrq_monitor: port checks of the request pin path, bus ack and reset value.
 * assumes binding into rcrq_top, one clock domain, synchronous reset.
 */
`timescale 1ns/1ps
module rcrq_monitor
    import rcrq_pkg::*;
(
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire logic         ce_i,
    input wire rcrq_wb_req_t wb_req_i,
    input wire logic         wb_ack_o,
    input wire logic         polarity_strap_i,
    input wire logic         combine_mode_strap_i,
    input wire logic         core_pwr_i,
    input wire logic         ext_req_i,
    input wire logic         req_pin_o,
    input wire logic         req_pin_oe_o,
    input wire logic         lpo_sel_o,
    input wire logic [19:0]  ref_khz_o
);
    // ---------------------------------------------------------------
    // helper state
    // ---------------------------------------------------------------
    logic en_reg;
    logic en_next;
    logic take;
    logic int_req;
    logic cmb;
    // bus request taken, internal request, combine active
    assign take    = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o & ce_i;
    assign int_req = core_pwr_i & ~lpo_sel_o;
    assign cmb     = en_reg & combine_mode_strap_i;
    // shadow of the request enable bit, from control writes
    always_comb begin
        en_next = en_reg;
        if (take && wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr == RCRQ_CTRL_OFS) begin
            en_next = wb_req_i.dat[RCRQ_CTRL_REQ_EN];
        end
    end
    always_ff @(posedge clk_i) begin
        en_reg <= rst_i ? 1'b1 : en_next;
    end
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    pin_or_a: assert property (cmb && polarity_strap_i |-> req_pin_o == (ext_req_i | int_req))
        else $error("request pin is not the or of both requests");
    pin_and_a: assert property (cmb && !polarity_strap_i |-> req_pin_o == (ext_req_i & ~int_req))
        else $error("request pin is not ext and not internal");
    pin_plain_a: assert property (en_reg && !combine_mode_strap_i |-> req_pin_o == (polarity_strap_i ~^ int_req))
        else $error("request pin wrong without combine");
    pin_unpowered_a: assert property (cmb && !core_pwr_i |-> req_pin_o == ext_req_i)
        else $error("combine path wrong with core unpowered");
    sleep_pin_a: assert property ($rose(lpo_sel_o) && en_reg && !combine_mode_strap_i |-> req_pin_o != polarity_strap_i)
        else $error("request still active in sleep");
    pin_drive_a: assert property (en_reg |-> req_pin_oe_o)
        else $error("request pin not driven");
    bus_answer_a: assert property (take |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ref_reset_a: assert property (disable iff (1'b0) $fell(rst_i) |-> ref_khz_o == RCRQ_REF_DEFAULT_KHZ)
        else $error("reference not at default after reset");
    // main scenarios reached
    or_hit_c: cover property (cmb && polarity_strap_i && ext_req_i && !int_req);
    sleep_c: cover property ($rose(lpo_sel_o));
    gpio_c: cover property (!en_reg && req_pin_oe_o);
    detect_c: cover property ($changed(ref_khz_o));
endmodule // rcrq_monitor

bind rcrq_top rcrq_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(wb_req_i),
    .wb_ack_o(wb_ack_o), .polarity_strap_i(polarity_strap_i), .combine_mode_strap_i(combine_mode_strap_i),
    .core_pwr_i(core_pwr_i), .ext_req_i(ext_req_i), .req_pin_o(req_pin_o), .req_pin_oe_o(req_pin_oe_o),
    .lpo_sel_o(lpo_sel_o), .ref_khz_o(ref_khz_o));

// ===== dv/rcrq_ref_model.sv
/*
 * rcrq_ref_model: far-side clocks, external low-power oscillator and the
 * reference divided by sixteen. assumes a 1 ns time unit.
 */
`timescale 1ns/1ps
module rcrq_ref_model (
    input  wire logic        lpo_run_i,
    input  wire logic [19:0] ref_khz_i,
    output logic             lpo_o,
    output logic             ref_o
);
    // low-power clock from time zero, stands low once stopped
    initial lpo_o = 1'b0;
    always begin
        #15259;
        lpo_o = lpo_run_i ? ~lpo_o : 1'b0;
    end
    // divided reference, free running
    initial ref_o = 1'b0;
    always begin
        #(8.0e6 / real'(ref_khz_i));
        ref_o = ~ref_o;
    end
endmodule // rcrq_ref_model

// ===== dv/tb.sv
/*
 * tb: self-checking bench of rcrq_top with the far-side clock model.
 * assumes short detection window and prescale of sixteen.
 */
`timescale 1ns/1ps
module tb;
    import rcrq_pkg::*;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic         ce = 1'b1;
    rcrq_wb_req_t wb_r = '0;
    logic [31:0]  wb_dat;
    logic         wb_ack;
    logic         pol = 1'b1;
    logic         comb = 1'b0;
    logic         pwr = 1'b1;
    logic         ext = 1'b0;
    logic         wake = 1'b0;
    logic         lrun = 1'b1;
    logic [19:0]  fkhz = 20'd26000;
    logic         low_power_oscillator, refd, pin, oe, lsel, lext;
    logic [19:0]  khz;
    logic [31:0]  q;
    int           n, fails = 0, samples_checked = 0;

    always #50 clk_i = ~clk_i;

    rcrq_top #(.DET_WIN_LPO(16), .PRESCALE(16), .TOL(2)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_req_i(wb_r), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .polarity_strap_i(pol),
        .combine_mode_strap_i(comb), .core_pwr_i(pwr), .ext_req_i(ext), .wake_i(wake), .lpo_ext_i(low_power_oscillator),
        .ref_div_i(refd), .req_pin_o(pin), .req_pin_oe_o(oe), .lpo_sel_o(lsel), .lpo_src_ext_o(lext),
        .ref_khz_o(khz));
    rcrq_ref_model model_u (.lpo_run_i(lrun), .ref_khz_i(fkhz), .lpo_o(low_power_oscillator), .ref_o(refd));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic bail();
        fails++;
        final_report();
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one classic cycle, held until ack is seen
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_r <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack !== 1'b1 && k < 20);
        if (wb_ack !== 1'b1) bail();
        rd = wb_dat;
        wb_r <= '0;
    endtask
    // expected pin from combine, polarity, ext, power
    function automatic logic exp_pin(input logic [3:0] v, input logic awake);
        logic c, p, x, r;
        {c, p, x, r} = v;
        r = r & awake;
        if (!c) return p ? r : !r;
        return p ? (x | r) : (x & !r);
    endfunction
    // every strap combination, then random ones
    task automatic sweep(input logic awake);
        logic [3:0] v;
        for (int i = 0; i < 48; i++) begin
            v = (i < 16) ? 4'(i) : 4'($urandom);
            @(posedge clk_i);
            {comb, pol, ext, pwr} <= v;
            @(negedge clk_i);
            chk(pin, exp_pin(v, awake), "req_pin");
        end
    endtask
    task automatic wait_khz(input logic [19:0] k);
        for (n = 0; n < 20000 && khz !== k; n++) @(posedge clk_i);
        if (n == 20000) bail();
        chk(khz, k, "ref_khz");
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'h74a3));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk(khz, RCRQ_REF_DEFAULT_KHZ, "ref_khz");
        wb(1'b0, RCRQ_CTRL_OFS, '0, q);
        chk(q, 32'(RCRQ_CTRL_RESET), "ctrl");
        wb(1'b0, 8'h10, '0, q);
        chk(q, '0, "unmapped");
        $display("test reset done");
        sweep(1'b1);
        wb(1'b1, RCRQ_CTRL_OFS, 32'h3, q);
        @(negedge clk_i);
        chk(lsel, 1'b1, "lpo_sel");
        sweep(1'b0);
        @(posedge clk_i);
        wake <= 1'b1;
        ce <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk(lsel, 1'b1, "frozen");
        ce <= 1'b1;
        for (n = 0; n < 10 && lsel !== 1'b0; n++) @(posedge clk_i);
        chk(lsel, 1'b0, "lpo_sel");
        wake <= 1'b0;
        wb(1'b0, RCRQ_CTRL_OFS, '0, q);
        chk(q, 32'h1, "ctrl");
        $display("test sleep done");
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, RCRQ_CTRL_OFS, 32'(i << 2), q);
            @(negedge clk_i);
            chk({oe, pin}, 32'(i), "gpio");
        end
        wb(1'b1, RCRQ_CTRL_OFS, 32'h1, q);
        $display("test gpio done");
        wait_khz(20'd26000);
        chk(lext, 1'b1, "lpo_ext");
        n = $urandom;
        wb(1'b1, RCRQ_REFKHZ_OFS, 32'(n[19:0]), q);
        wb(1'b0, RCRQ_REFKHZ_OFS, '0, q);
        chk(q, 32'(n[19:0]), "refkhz");
        @(posedge clk_i);
        fkhz <= 20'd38400;
        wb(1'b1, RCRQ_CTRL_OFS, 32'h11, q);
        wait_khz(20'd38400);
        @(posedge clk_i);
        fkhz <= 20'd22000;
        wb(1'b1, RCRQ_CTRL_OFS, 32'h11, q);
        for (n = 0; n < 4000; n++) begin
            wb(1'b0, RCRQ_STATUS_OFS, '0, q);
            if (q[RCRQ_ST_DET_DONE] === 1'b1) break;
        end
        if (n == 4000) bail();
        chk(q[RCRQ_ST_DET_HIT], 1'b0, "det_hit");
        chk(khz, 20'd38400, "ref_khz");
        $display("test detect done");
        @(posedge clk_i);
        lrun <= 1'b0;
        for (n = 0; n < 2000 && lext !== 1'b0; n++) @(posedge clk_i);
        chk(lext, 1'b0, "lpo_ext");
        $display("test lpo loss done");
        final_report();
    end
endmodule // tb
